// file: logic/i2clt_pkg.sv
/*
  Shared constants and types for the I2C transfer-length and transmit
  queue block. Assumes a 100 MHz pclk and an 8-bit APB byte address.
*/
`default_nettype none
package i2clt_pkg;
  // ==========================================
  // register byte addresses
  localparam logic [7:0] ADR_SCFG = 8'h04;
  localparam logic [7:0] ADR_MCTL = 8'h0c;
  localparam logic [7:0] ADR_TXP = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h14;
  localparam logic [7:0] ADR_RXD = 8'h18;
  localparam logic [7:0] ADR_RIS = 8'h20;
  localparam logic [7:0] ADR_MASK = 8'h24;
  localparam logic [7:0] ADR_DMA = 8'h28;
  // ==========================================
  // field positions and reset values
  localparam int MC_OP = 0;
  localparam int MC_LEN_LSB = 15;
  localparam int LEN_W = 11;
  localparam logic [6:0] SCFG_RST = 7'h55;
  localparam int DMA_EN = 0;
  localparam int DMA_BS_LSB = 1;
  localparam int RI_TXNE = 0;
  localparam int RI_SLAVE_READ_REQUEST_FLAG = 1;
  localparam int RI_SLAVE_MORE_DATA_FLAG = 2;
  localparam int RI_STD = 3;
  localparam int RI_MTD = 4;
  localparam int RIS_W = 5;
  // ==========================================
  // queue sizes
  localparam int TXAW = 3;
  localparam logic [TXAW:0] TXD = 4'h8;
  localparam logic [TXAW:0] TXNE_THR = 4'h2;
  localparam int RXAW = 2;
  localparam logic [RXAW:0] RXD = 3'h4;
  // ==========================================
  // status codes
  localparam logic [1:0] OPC_MW = 2'h0;
  localparam logic [1:0] OPC_MR = 2'h1;
  localparam logic [1:0] OPC_RFS = 2'h3;
  localparam logic [1:0] ST_NOP = 2'h0;
  localparam logic [1:0] ST_ONGO = 2'h1;
  localparam logic [1:0] ST_OK = 2'h2;
  localparam logic [1:0] ST_ABORT = 2'h3;
  localparam logic [2:0] CS_NACK_ADDR = 3'h0;
  localparam logic [2:0] CS_NACK_DATA = 3'h1;
  // ==========================================
  // bus timing: half of a 100 kHz bit
  localparam int CLK_NS = 10;
  localparam int T_HALF_NS = 5000;
  localparam logic [9:0] HALF_CYC = 10'(T_HALF_NS / CLK_NS);
  // ==========================================
  // state machines
  typedef enum logic [2:0] {MS_IDLE, MS_START, MS_BIT, MS_ACK, MS_STOP} i2clt_mst_t;
  typedef enum logic [2:0] {SS_IDLE, SS_ADDR, SS_AACK, SS_TX, SS_TXB, SS_TACK,
                            SS_TWAIT} i2clt_slv_t;
endpackage
`default_nettype wire

// file: logic/i2clt_top.sv
/*
  I2C controller core: master write/read with programmed length, slave
  read-from-slave with transmit queue, APB registers, interrupt, DMA.
  Assumes open-drain pads resolved outside and a DMA engine writing the
  transmit port over APB.
*/
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - length field sets master byte count
// - master write drains queue, refilled live
// - master read nacks last programmed byte
// - full receive queue stretches clock low
// - port write pushes byte, bit0 first
// - master write waits for queued byte
// - addressed read raises read-request flag
// - empty queue mid-read raises more-data flag
// - slave stretches clock until data present
// - queue flushed as read-request flag sets
// - slave read end flags done, status
// - cpu mode flags queue nearly empty
// - dma single/burst by free room
// - dma slave read ends with dummy final request
// - operation bit picks write or read
// - status shows last op and state
module i2clt_top import i2clt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oen,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen,
  output logic dma_sreq,
  output logic dma_breq,
  output logic dma_last
);
  // ==========================================
  // pin synchronisers and edge finding
  logic [1:0] scl_sy_q, sda_sy_q;
  logic scl_d1_q, sda_d1_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
      scl_d1_q <= scl_sy_q[1];
      sda_d1_q <= sda_sy_q[1];
    end
  end
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  assign scl_s = scl_sy_q[1];
  assign sda_s = sda_sy_q[1];
  assign scl_rise = scl_s & ~scl_d1_q;
  assign scl_fall = ~scl_s & scl_d1_q;
  assign start_det = ~sda_s & sda_d1_q & scl_s;
  assign stop_det = sda_s & ~sda_d1_q & scl_s;

  // ==========================================
  // apb slave: one wait state, data captured before completion
  logic pready_q, pslverr_q, acc, wr_en, rd_en, hit;
  logic [31:0] prdata_q, rd_mux;
  logic [6:0] scfg_q;
  logic [31:0] mctl_q;
  logic [7:0] txp_q;
  logic [2:0] dma_q;
  logic [RIS_W-1:0] ris_q, mask_q;
  logic [1:0] op_q, st_q;
  logic [2:0] cause_q;
  logic [7:0] tx_head, rx_head;
  assign acc = psel & penable & pready_q;
  assign wr_en = acc & pwrite;
  assign rd_en = acc & ~pwrite;
  // read decode, unmapped answers zero with error
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0;
    if (paddr == ADR_SCFG) begin
      rd_mux = {25'h0, scfg_q};
    end else if (paddr == ADR_MCTL) begin
      rd_mux = mctl_q;
    end else if (paddr == ADR_TXP) begin
      rd_mux = {24'h0, txp_q};
    end else if (paddr == ADR_STAT) begin
      rd_mux = {25'h0, cause_q, st_q, op_q};
    end else if (paddr == ADR_RXD) begin
      rd_mux = {24'h0, rx_head};
    end else if (paddr == ADR_RIS) begin
      rd_mux = {27'h0, ris_q};
    end else if (paddr == ADR_MASK) begin
      rd_mux = {27'h0, mask_q};
    end else if (paddr == ADR_DMA) begin
      rd_mux = {29'h0, dma_q};
    end else begin
      hit = 1'b0;
    end
  end
  // handshake and read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
        prdata_q <= pwrite ? 32'h0 : rd_mux;
        pslverr_q <= ~hit;
      end
    end
  end
  // software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scfg_q <= SCFG_RST;
      mctl_q <= 32'h0;
      txp_q <= 8'h0;
      dma_q <= 3'h0;
      mask_q <= '0;
    end else if (wr_en) begin
      if (paddr == ADR_SCFG) scfg_q <= pwdata[6:0];
      if (paddr == ADR_MCTL) mctl_q <= pwdata;
      if (paddr == ADR_TXP) txp_q <= pwdata[7:0];
      if (paddr == ADR_DMA) dma_q <= pwdata[2:0];
      if (paddr == ADR_MASK) mask_q <= pwdata[RIS_W-1:0];
    end
  end

  // ==========================================
  // transmit and receive queues
  // depths from package
  logic [7:0] txm_q [2**TXAW];
  logic [7:0] rxm_q [2**RXAW];
  logic [TXAW-1:0] txw_q, txr_q;
  logic [TXAW:0] txc_q;
  logic [RXAW-1:0] rxw_q, rxr_q;
  logic [RXAW:0] rxc_q;
  logic tx_push, tx_pop, tx_flush, rx_push, rx_pop, rx_full;
  logic m_pop_q, s_pop_q, s_flush_q, m_rpush_q;
  logic [7:0] m_sh_q;
  assign tx_push = wr_en && paddr == ADR_TXP && txc_q != TXD;
  assign tx_pop = m_pop_q | s_pop_q;
  assign tx_flush = s_flush_q;
  assign tx_head = txm_q[txr_q];
  assign rx_push = m_rpush_q && !rx_full;
  assign rx_pop = rd_en && paddr == ADR_RXD && rxc_q != '0;
  assign rx_full = rxc_q == RXD;
  assign rx_head = rxm_q[rxr_q];
  // storage, no reset needed
  always_ff @(posedge pclk) begin
    if (tx_push) txm_q[txw_q] <= pwdata[7:0];
    if (rx_push) rxm_q[rxw_q] <= m_sh_q;
  end
  // pointers; flush beats push and pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txw_q <= '0;
      txr_q <= '0;
      txc_q <= '0;
      rxw_q <= '0;
      rxr_q <= '0;
      rxc_q <= '0;
    end else begin
      if (tx_flush) begin
        txw_q <= '0;
        txr_q <= '0;
        txc_q <= '0;
      end else begin
        if (tx_push) txw_q <= txw_q + 1'b1;
        if (tx_pop) txr_q <= txr_q + 1'b1;
        txc_q <= txc_q + (TXAW+1)'(tx_push) - (TXAW+1)'(tx_pop);
      end
      if (rx_push) rxw_q <= rxw_q + 1'b1;
      if (rx_pop) rxr_q <= rxr_q + 1'b1;
      rxc_q <= rxc_q + (RXAW+1)'(rx_push) - (RXAW+1)'(rx_pop);
    end
  end

  // ==========================================
  // master engine
  i2clt_mst_t m_st_q;
  i2clt_slv_t s_st_q;
  logic m_half_q, m_adr_q, m_rd_q, m_scl_q, m_sda_q, m_ld_q;
  logic m_go_q, m_start_q, m_done_q, m_ab_q;
  logic [2:0] m_bit_q, m_cause_q;
  logic [9:0] m_tc_q;
  logic [LEN_W-1:0] m_left_q;
  logic tend, m_rx, m_stall;
  assign tend = m_tc_q == HALF_CYC - 10'h1;
  assign m_rx = m_rd_q & ~m_adr_q;
  assign m_stall = !m_half_q && m_bit_q == 3'h0 && (m_ld_q || (m_rx && rx_full));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_st_q <= MS_IDLE;
      m_half_q <= 1'b0;
      m_adr_q <= 1'b0;
      m_rd_q <= 1'b0;
      m_scl_q <= 1'b0;
      m_sda_q <= 1'b0;
      m_ld_q <= 1'b0;
      m_bit_q <= 3'h0;
      m_tc_q <= 10'h0;
      m_sh_q <= 8'h0;
      m_left_q <= '0;
      m_pop_q <= 1'b0;
      m_rpush_q <= 1'b0;
      m_start_q <= 1'b0;
      m_done_q <= 1'b0;
      m_ab_q <= 1'b0;
      m_cause_q <= 3'h0;
    end else begin
      m_pop_q <= 1'b0;
      m_rpush_q <= 1'b0;
      m_start_q <= 1'b0;
      m_done_q <= 1'b0;
      if (m_st_q != MS_IDLE && !m_stall) m_tc_q <= tend ? 10'h0 : m_tc_q + 10'h1;
      case (m_st_q)
        MS_IDLE: begin
          m_tc_q <= 10'h0;
          if (m_go_q && s_st_q == SS_IDLE && (mctl_q[MC_OP] || txc_q != '0)) begin
            m_st_q <= MS_START;
            m_start_q <= 1'b1;
            m_rd_q <= mctl_q[MC_OP];
            m_left_q <= mctl_q[MC_LEN_LSB +: LEN_W];
            m_sh_q <= mctl_q[7:0];
            m_adr_q <= 1'b1;
            m_bit_q <= 3'h0;
            m_half_q <= 1'b0;
            m_ab_q <= 1'b0;
            m_sda_q <= 1'b1;
          end
        end
        MS_START: begin
          if (tend) begin
            m_scl_q <= 1'b1;
            m_sda_q <= ~m_sh_q[7];
            m_st_q <= MS_BIT;
          end
        end
        MS_BIT: begin
          if (m_ld_q && !m_half_q && txc_q != '0) begin
            m_sh_q <= tx_head;
            m_sda_q <= ~tx_head[0];
            m_pop_q <= 1'b1;
            m_ld_q <= 1'b0;
          end
          if (tend && !m_stall && !m_half_q) begin
            m_half_q <= 1'b1;
            m_scl_q <= 1'b0;
          end else if (tend && m_half_q) begin
            m_half_q <= 1'b0;
            m_scl_q <= 1'b1;
            if (m_rx) m_sh_q <= {sda_s, m_sh_q[7:1]};
            else if (m_adr_q) m_sh_q <= {m_sh_q[6:0], 1'b0};
            else m_sh_q <= {1'b0, m_sh_q[7:1]};
            if (m_bit_q == 3'h7) begin
              m_st_q <= MS_ACK;
              m_rpush_q <= m_rx;
              m_sda_q <= m_rx && m_left_q != 11'h1;
            end else begin
              m_bit_q <= m_bit_q + 3'h1;
              m_sda_q <= m_rx ? 1'b0 : ~(m_adr_q ? m_sh_q[6] : m_sh_q[1]);
            end
          end
        end
        MS_ACK: begin
          if (tend && !m_half_q) begin
            m_half_q <= 1'b1;
            m_scl_q <= 1'b0;
          end else if (tend) begin
            m_half_q <= 1'b0;
            m_scl_q <= 1'b1;
            m_bit_q <= 3'h0;
            m_sda_q <= 1'b0;
            m_st_q <= MS_BIT;
            if (!m_rx && sda_s) begin
              m_ab_q <= 1'b1;
              m_cause_q <= m_adr_q ? CS_NACK_ADDR : CS_NACK_DATA;
              m_sda_q <= 1'b1;
              m_st_q <= MS_STOP;
            end else if (m_adr_q && m_left_q == '0) begin
              m_sda_q <= 1'b1;
              m_st_q <= MS_STOP;
            end else if (!m_adr_q && m_left_q == 11'h1) begin
              m_left_q <= '0;
              m_sda_q <= 1'b1;
              m_st_q <= MS_STOP;
            end else begin
              m_adr_q <= 1'b0;
              if (!m_adr_q) m_left_q <= m_left_q - 11'h1;
              m_ld_q <= !m_rd_q;
            end
          end
        end
        MS_STOP: begin
          if (tend && !m_half_q) begin
            m_half_q <= 1'b1;
            m_scl_q <= 1'b0;
          end else if (tend) begin
            m_half_q <= 1'b0;
            m_sda_q <= 1'b0;
            m_done_q <= 1'b1;
            m_st_q <= MS_IDLE;
          end
        end
        default: m_st_q <= MS_IDLE;
      endcase
    end
  end
  // start request, held until the master leaves idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) m_go_q <= 1'b0;
    else if (wr_en && paddr == ADR_MCTL) m_go_q <= 1'b1;
    else if (m_start_q) m_go_q <= 1'b0;
  end

  // ==========================================
  // slave read-from-slave engine
  logic [2:0] s_bit_q;
  logic [7:0] s_sh_q;
  logic s_first_q, s_asked_q, s_scl_q, s_sda_q, s_more_q, s_done_q;
  logic [7:0] s_adr;
  assign s_adr = {s_sh_q[6:0], sda_s};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_st_q <= SS_IDLE;
      s_bit_q <= 3'h0;
      s_sh_q <= 8'h0;
      s_first_q <= 1'b0;
      s_asked_q <= 1'b0;
      s_scl_q <= 1'b0;
      s_sda_q <= 1'b0;
      s_pop_q <= 1'b0;
      s_flush_q <= 1'b0;
      s_more_q <= 1'b0;
      s_done_q <= 1'b0;
    end else begin
      s_pop_q <= 1'b0;
      s_flush_q <= 1'b0;
      s_more_q <= 1'b0;
      s_done_q <= 1'b0;
      case (s_st_q)
        SS_ADDR: begin
          if (scl_rise) begin
            s_sh_q <= s_adr;
            s_bit_q <= s_bit_q + 3'h1;
            if (s_bit_q == 3'h7 && s_adr == {scfg_q, 1'b1}) begin
              s_st_q <= SS_AACK;
              s_flush_q <= 1'b1;
              s_first_q <= 1'b1;
            end else if (s_bit_q == 3'h7) begin
              s_st_q <= SS_IDLE;
            end
          end
        end
        SS_AACK: begin
          if (scl_fall && !s_sda_q) begin
            s_sda_q <= 1'b1;
          end else if (scl_fall) begin
            s_sda_q <= 1'b0;
            s_scl_q <= 1'b1;
            s_st_q <= SS_TX;
          end
        end
        SS_TX: begin
          if (txc_q != '0 && !tx_flush) begin
            s_sh_q <= tx_head;
            s_sda_q <= ~tx_head[0];
            s_pop_q <= 1'b1;
            s_bit_q <= 3'h0;
            s_first_q <= 1'b0;
            s_asked_q <= 1'b0;
            s_st_q <= SS_TXB;
          end else if (!s_first_q && !s_asked_q) begin
            s_more_q <= 1'b1;
            s_asked_q <= 1'b1;
          end
        end
        SS_TXB: begin
          if (s_scl_q && !s_pop_q) s_scl_q <= 1'b0;
          if (scl_fall && s_bit_q == 3'h7) begin
            s_sda_q <= 1'b0;
            s_st_q <= SS_TACK;
          end else if (scl_fall) begin
            s_sh_q <= {1'b0, s_sh_q[7:1]};
            s_sda_q <= ~s_sh_q[1];
            s_bit_q <= s_bit_q + 3'h1;
          end
        end
        SS_TACK: begin
          if (scl_rise && sda_s) begin
            s_done_q <= 1'b1;
            s_st_q <= SS_IDLE;
          end else if (scl_rise) begin
            s_st_q <= SS_TWAIT;
          end
        end
        SS_TWAIT: begin
          if (scl_fall) begin
            s_scl_q <= 1'b1;
            s_st_q <= SS_TX;
          end
        end
        default: s_st_q <= SS_IDLE;
      endcase
      if (start_det && m_st_q == MS_IDLE) begin
        s_st_q <= SS_ADDR;
        s_bit_q <= 3'h0;
        s_scl_q <= 1'b0;
        s_sda_q <= 1'b0;
      end else if (stop_det) begin
        s_st_q <= SS_IDLE;
        s_scl_q <= 1'b0;
        s_sda_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // status, interrupts, dma requests and pads
  logic [RIS_W-1:0] ris_set;
  logic [TXAW:0] tx_free, burst;
  logic txne_ev, dma_act, irq_q, dma_sreq_q, dma_breq_q, dma_last_q;
  logic scl_o_q, scl_oen_q, sda_o_q, sda_oen_q, sda_pull_q;
  assign txne_ev = tx_pop && !tx_flush && txc_q == TXNE_THR + 4'h1 && !dma_q[DMA_EN];
  assign ris_set = {m_done_q, s_done_q, s_more_q, s_flush_q, txne_ev};
  assign tx_free = TXD - txc_q;
  assign burst = (TXAW+1)'(1) << dma_q[DMA_BS_LSB +: 2];
  assign dma_act = (m_st_q != MS_IDLE && !m_rd_q) || (s_st_q >= SS_AACK);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= OPC_MW;
      st_q <= ST_NOP;
      cause_q <= 3'h0;
    end else begin
      if (m_start_q) begin
        op_q <= m_rd_q ? OPC_MR : OPC_MW;
        st_q <= ST_ONGO;
      end
      if (m_done_q) begin
        st_q <= m_ab_q ? ST_ABORT : ST_OK;
        cause_q <= m_cause_q;
      end
      if (s_flush_q) begin
        op_q <= OPC_RFS;
        st_q <= ST_ONGO;
      end
      if (s_done_q) st_q <= ST_OK;
    end
  end
  // sticky flags, read clears what was returned, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ris_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ris_q <= (ris_q & ~((rd_en && paddr == ADR_RIS) ? prdata_q[RIS_W-1:0] : '0)) | ris_set;
      irq_q <= |(ris_q & mask_q);
    end
  end
  // single or burst by free room
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_sreq_q <= 1'b0;
      dma_breq_q <= 1'b0;
      dma_last_q <= 1'b0;
    end else if (dma_q[DMA_EN] && s_done_q) begin
      dma_last_q <= 1'b1;
      dma_breq_q <= burst != 4'h1;
      dma_sreq_q <= burst == 4'h1;
    end else begin
      dma_last_q <= 1'b0;
      dma_breq_q <= dma_q[DMA_EN] && dma_act && tx_free >= burst && burst != 4'h1;
      dma_sreq_q <= dma_q[DMA_EN] && dma_act && tx_free != '0 && !(tx_free >= burst && burst != 4'h1);
    end
  end
  // open-drain pads, enable low means pull low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
      scl_oen_q <= 1'b1;
      sda_oen_q <= 1'b1;
      sda_pull_q <= 1'b0;
    end else begin
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
      scl_oen_q <= ~(m_scl_q | s_scl_q);
      // sda trails scl by a clock so data never moves on a clock edge
      sda_pull_q <= m_sda_q | s_sda_q;
      sda_oen_q <= ~sda_pull_q;
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign scl_o = scl_o_q;
  assign scl_oen = scl_oen_q;
  assign sda_o = sda_o_q;
  assign sda_oen = sda_oen_q;
  assign dma_sreq = dma_sreq_q;
  assign dma_breq = dma_breq_q;
  assign dma_last = dma_last_q;

  // ==========================================
  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_LEN_LOAD: assert property (m_start_q |-> m_left_q == mctl_q[MC_LEN_LSB +: LEN_W])
    else $error("length not loaded");
  AST_PREFILL: assert property (m_start_q && !m_rd_q |-> $past(txc_q) != '0)
    else $error("write began with empty queue");
  AST_RX_STALL: assert property (m_st_q == MS_BIT && m_rx && m_stall |=> !scl_oen_q && $stable(m_tc_q))
    else $error("no stretch on full rx");
  AST_NACK_LAST: assert property (m_st_q == MS_ACK && m_rx && m_left_q == 11'h1 |=> sda_oen_q)
    else $error("last byte acked");
  AST_PUSH: assert property (tx_push && !tx_pop && !tx_flush |=> txc_q == $past(txc_q) + 4'h1)
    else $error("push lost");
  AST_FLUSH: assert property (s_flush_q |=> txc_q == '0 && ris_q[RI_SLAVE_READ_REQUEST_FLAG])
    else $error("flush or request flag missing");
  AST_SLV_STRETCH: assert property (s_st_q == SS_TX && txc_q == '0 |=> !scl_oen_q)
    else $error("slave released clock without data");
  AST_STD: assert property (s_done_q |=> ris_q[RI_STD] && st_q == ST_OK)
    else $error("slave done not flagged");
  AST_DMA_LAST: assert property (s_done_q && dma_q[DMA_EN] |=> dma_last_q && (dma_sreq_q || dma_breq_q))
    else $error("no dummy request");
  COV_MW: cover property (m_done_q && !m_rd_q && !m_ab_q);
  COV_MR: cover property (m_done_q && m_rd_q);
  COV_RFS: cover property (s_done_q);
  COV_RXSTALL: cover property (m_stall && m_rx ##1 !m_stall);
endmodule
`default_nettype wire

// file: test/i2c_length_and_tx_fifo_tb_top.sv
/*
  Testbench: APB register tasks, master write and read against the
  slave partner, interrupt mask and clear.
  Assumes 100 MHz pclk and a pulled-up I2C bus.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_length_and_tx_fifo_tb_top import i2clt_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, scl_o, scl_oen, sda_o, sda_oen, m_oen, err;
  logic dma_sreq, dma_breq, dma_last;
  wire logic scl = scl_oen;
  wire logic sda = sda_oen & m_oen;
  int n_errors = 0;
  int cmp_count = 0;
  always #5 pclk = ~pclk;
  i2clt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .scl_i(scl), .scl_o(scl_o), .scl_oen(scl_oen),
    .sda_i(sda), .sda_o(sda_o), .sda_oen(sda_oen), .dma_sreq(dma_sreq), .dma_breq(dma_breq),
    .dma_last(dma_last));
  i2clt_slave_model peer (.scl(scl), .sda(sda), .sda_oen(m_oen));
  // ==========================================
  // shared tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    $display("errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_done(input string nm, input logic [31:0] exp);
    int i;
    for (i = 0; i < 800; i++) begin
      repeat (50) @(posedge pclk);
      apb(1'b0, ADR_STAT, 32'h0);
      if (rd[3:2] === ST_OK || rd[3:2] === ST_ABORT) break;
    end
    if (i == 800) begin
      n_errors++;
      conclude();
    end
    chk(nm, rd, exp);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADR_SCFG, 32'h0);
    chk("slave address reset", rd, {25'h0, SCFG_RST});
    apb(1'b0, ADR_TXP, 32'h0);
    chk("tx port reset", rd, 32'h0);
    apb(1'b0, ADR_STAT, 32'h0);
    chk("status reset", rd, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, ADR_MCTL, (32'h3 << MC_LEN_LSB) | 32'h44);
    repeat (2000) @(posedge pclk);
    chk("bus idle without data", {30'h0, scl, sda}, 32'h3);
    apb(1'b1, ADR_TXP, 32'h3c);
    apb(1'b1, ADR_TXP, 32'h81);
    apb(1'b1, ADR_TXP, 32'he7);
    wait_done("write status", {28'h0, ST_OK, OPC_MW});
    chk("bytes framed", peer.nbyte, 32'h4);
    chk("byte 0", peer.got[0], 32'h3c);
    chk("byte 1", peer.got[1], 32'h81);
    chk("byte 2", peer.got[2], 32'he7);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, ADR_MASK, 32'h10);
    repeat (3) @(posedge pclk);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b0, ADR_RIS, 32'h0);
    chk("raw status", rd, 32'h11);
    repeat (3) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, ADR_MCTL, (32'h2 << MC_LEN_LSB) | 32'h45);
    wait_done("read status", {28'h0, ST_OK, OPC_MR});
    apb(1'b0, ADR_RXD, 32'h0);
    chk("read byte 0", rd, 32'hc1);
    apb(1'b0, ADR_RXD, 32'h0);
    chk("read byte 1", rd, 32'hc2);
    chk("ack first", {31'h0, peer.ack_seen[1]}, 32'h0);
    chk("nack last", {31'h0, peer.ack_seen[2]}, 32'h1);
    chk("read framed", peer.nbyte, 32'h3);
    // address-only write with dma requests watched
    apb(1'b1, ADR_TXP, 32'h5a);
    apb(1'b1, ADR_DMA, 32'h3);
    apb(1'b1, ADR_MCTL, 32'h44);
    repeat (100) @(posedge pclk);
    chk("dma burst", {30'h0, dma_breq, dma_sreq}, 32'h2);
    chk("pad data", {30'h0, scl_o, sda_o}, 32'h0);
    apb(1'b1, ADR_DMA, 32'h7);
    repeat (3) @(posedge pclk);
    chk("dma single", {29'h0, dma_last, dma_breq, dma_sreq}, 32'h1);
    wait_done("address only status", {28'h0, ST_OK, OPC_MW});
    chk("address only framed", peer.nbyte, 32'h1);
    chk("dma idle", {30'h0, dma_breq, dma_sreq}, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire

// file: test/i2clt_slave_model.sv
/*
  I2C slave partner: acks the address and each written byte, returns
  bytes 0xc1, 0xc2, ... on reads, lsb first.
  Assumes a wired-AND bus with pull-ups resolved by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module i2clt_slave_model (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oen
);
  logic [7:0] sh;
  logic [7:0] got [0:7];
  logic ack_seen [0:7];
  logic rd;
  logic done;
  int bitc;
  int nbyte;
  initial sda_oen = 1'b1;
  // start condition opens a frame
  always @(negedge sda) begin
    if (scl) begin
      bitc = 0;
      nbyte = 0;
      rd = 1'b0;
      done = 1'b0;
    end
  end
  // address shifts in msb first, data lsb first
  always @(posedge scl) begin
    if (bitc < 8) sh = (nbyte == 0) ? {sh[6:0], sda} : {sda, sh[7:1]};
    else ack_seen[nbyte] = sda;
    if (bitc == 8 && rd && nbyte > 0 && sda) done = 1'b1;
    bitc++;
  end
  // drive ack or read data while scl is low, else release
  always @(negedge scl) begin
    if (bitc == 9) begin
      if (nbyte == 0) rd = sh[0];
      else got[nbyte-1] = sh;
      bitc = 0;
      nbyte++;
    end
    sda_oen = 1'b1;
    if (bitc == 8 && !(rd && nbyte > 0)) sda_oen = 1'b0;
    if (rd && !done && nbyte > 0 && bitc < 8) sda_oen = 1'((8'hc0 + 8'(nbyte)) >> bitc);
  end
endmodule
`default_nettype wire
